// ===== hw/tsoc_port.sv
// Serial output port of one receiver channel, slave and cascade operation.
// Core side delivers I/Q pairs on clock; link side runs on shift_clock.
//
// Summary of operation
// RULE1: The link logic runs on the host shift clock, asynchronous to clock.
// RULE2: The host keeps the shift clock at or below 62.5 MHz and fast enough.
// RULE3: Pairs arrive at the filter-chain output rate, one per pair_valid.
// RULE4: A cascaded upstream port floats its data while the next one drives.
// RULE5: Frame end of one port feeds the frame sync of the next port.
// RULE6: The chain head is a master port; followers are slave ports. Here every port is a slave; the head takes its frame sync from the host.
// RULE7: Any number of slave ports may be chained frame end to frame sync.
// RULE8: The host gives enough shift clocks for all chained frames.
// RULE9: The first data bit is driven on the rising edge after the sync.
// RULE10: The host samples data until the word-length bit count is reached.
// RULE11: A host that cannot count bits watches the frame end output.
// RULE12: Timing is the same in master and slave; only the source differs.
// RULE13: Frame sync is sampled on the falling shift clock edge.
// RULE14: Frame end is high during the last bit, the LSB of the Q word.
// RULE15: Words are 12, 16 or 24 bits; I first MSB first, then Q.
// RULE16: Outside its slot the data output is not driven.
// RULE17: Edges without a sync are ignored; a frame needs a fresh pair.
`timescale 1ns/10ps
module tsoc_port
(
   input wire logic clock,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic [1:0] word_length,
   input wire logic [23:0] i_word,
   input wire logic [23:0] q_word,
   input wire logic pair_valid,
   input wire logic frame_sync_pulse,
   output logic serial_data_out,
   output logic serial_data_out_en,
   output logic frame_end_flag,
   output logic channel_data_ready
);
   // ==================================================================
   // Core domain: hold one pair, hand it over by toggle
   logic [47:0] pair_buf;
   logic [47:0] next_pair_buf;
   logic [1:0] wl_buf;
   logic [1:0] next_wl_buf;
   logic req_tog;
   logic next_req_tog;
   logic ready;
   logic next_ready;
   logic ack_s1;
   logic ack_s2;
   logic ack_s3;
   logic ack_tog;
   logic link_reset_s1;
   logic link_reset;

   always_comb
   begin
      next_pair_buf = pair_buf;
      next_wl_buf = wl_buf;
      next_req_tog = req_tog;
      next_ready = ready;
      // Pair taken by the link: buffer empties
      if (ack_s3 != ack_s2)
      begin
         next_ready = 1'b0;
      end
      // A new pair overwrites an unread one; the host fell behind
      if (pair_valid) // [RULE3]
      begin
         next_pair_buf = {i_word, q_word};
         next_wl_buf = word_length;
         next_req_tog = ~req_tog;
         next_ready = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pair_buf <= tsoc_pkg::SHIFT_RESET;
         wl_buf <= tsoc_pkg::WL_12;
         req_tog <= 1'b0;
         ready <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end
      else
      begin
         pair_buf <= next_pair_buf;
         wl_buf <= next_wl_buf;
         req_tog <= next_req_tog;
         ready <= next_ready;
         ack_s1 <= ack_tog;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end

   assign channel_data_ready = ready;

   // ==================================================================
   // Link domain reset: asserted at once, released on shift_clock
   always_ff @(posedge shift_clock or posedge reset)
   begin
      if (reset)
      begin
         link_reset_s1 <= 1'b1;
         link_reset <= 1'b1;
      end
      else
      begin
         link_reset_s1 <= 1'b0;
         link_reset <= link_reset_s1;
      end
   end

   // ==================================================================
   // Link domain: request toggle crossing, sampled at rising edges
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic next_req_seen;
   logic next_ack_tog;
   logic fresh;
   logic next_fresh;
   logic [47:0] shreg;
   logic [47:0] next_shreg;
   logic [5:0] bit_cnt;
   logic [5:0] next_bit_cnt;
   logic [5:0] word_bits;
   logic [5:0] next_word_bits;
   logic half;
   logic next_half;
   logic sync_fall;
   logic data_q;
   logic next_data_q;
   logic en_q;
   logic next_en_q;
   logic fe_q;
   logic next_fe_q;
   tsoc_pkg::tsoc_state_type state;
   tsoc_pkg::tsoc_state_type next_state;

   function automatic logic [5:0] tsoc_bits(input logic [1:0] wl);
      case (wl) // [RULE15]
         tsoc_pkg::WL_12: tsoc_bits = tsoc_pkg::BITS_12;
         tsoc_pkg::WL_16: tsoc_bits = tsoc_pkg::BITS_16;
         default: tsoc_bits = tsoc_pkg::BITS_24;
      endcase
   endfunction

   // Sync is caught on the falling edge so the frame may start on the
   // very next rising edge; the host keeps it stable around that edge
   always_ff @(negedge shift_clock or posedge reset)
   begin
      if (reset)
      begin
         sync_fall <= 1'b0;
      end
      else
      begin
         sync_fall <= frame_sync_pulse; // [RULE13] [RULE5] [RULE6]
      end
   end

   // Picks the MSB of I for bit 0, then of Q after word_bits bits
   function automatic logic tsoc_bit(input logic [47:0] sr,
                                     input logic [5:0] n,
                                     input logic h);
      logic [5:0] idx;
      idx = 6'(tsoc_pkg::WORD_MAX - 1) - n;
      tsoc_bit = h ? sr[idx] : sr[6'(tsoc_pkg::WORD_MAX) + idx];
   endfunction

   always_comb
   begin
      next_req_seen = req_seen;
      next_ack_tog = ack_tog;
      next_fresh = fresh;
      next_shreg = shreg;
      next_bit_cnt = bit_cnt;
      next_word_bits = word_bits;
      next_half = half;
      next_data_q = data_q;
      next_en_q = 1'b0; // [RULE16] [RULE4]
      next_fe_q = 1'b0;
      next_state = state;
      if (req_s2 != req_seen)
      begin
         next_req_seen = req_s2;
         next_fresh = 1'b1;
      end
      case (state)
         tsoc_pkg::TSOC_IDLE, tsoc_pkg::TSOC_ARMED:
         begin
            // Without a sync or a fresh pair the edges do nothing
            if (sync_fall && fresh) // [RULE17] [RULE9] [RULE1]
            begin
               next_shreg = pair_buf;
               next_word_bits = tsoc_bits(wl_buf);
               next_ack_tog = ~ack_tog;
               next_fresh = 1'b0;
               next_data_q = tsoc_bit(pair_buf, tsoc_pkg::CNT_RESET, 1'b0);
               next_en_q = 1'b1;
               next_bit_cnt = 6'h01;
               next_half = 1'b0;
               next_state = tsoc_pkg::TSOC_SHIFT;
            end
            else
            begin
               next_state = fresh ? tsoc_pkg::TSOC_ARMED
                                  : tsoc_pkg::TSOC_IDLE;
            end
         end
         tsoc_pkg::TSOC_SHIFT:
         begin
            if (bit_cnt == word_bits && half)
            begin
               // Last bit has had its cycle; release the line
               next_state = tsoc_pkg::TSOC_IDLE; // [RULE4]
               next_bit_cnt = tsoc_pkg::CNT_RESET;
            end
            else
            begin
               next_en_q = 1'b1; // [RULE12]
               if (bit_cnt == word_bits)
               begin
                  next_half = 1'b1;
                  next_bit_cnt = 6'h01;
                  next_data_q = tsoc_bit(shreg, tsoc_pkg::CNT_RESET, 1'b1);
                  next_fe_q = (word_bits == 6'h01);
               end
               else
               begin
                  next_bit_cnt = bit_cnt + 6'h01;
                  next_data_q = tsoc_bit(shreg, bit_cnt, half);
                  // Raised with the Q LSB, for the host or the next port
                  next_fe_q = half && (bit_cnt + 6'h01 == word_bits);
                  // [RULE14] [RULE11] [RULE7]
               end
            end
         end
         default:
         begin
            next_state = tsoc_pkg::TSOC_IDLE;
         end
      endcase
   end

   always_ff @(posedge shift_clock or posedge reset)
   begin
      if (reset)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
         ack_tog <= 1'b0;
         fresh <= 1'b0;
         shreg <= tsoc_pkg::SHIFT_RESET;
         bit_cnt <= tsoc_pkg::CNT_RESET;
         word_bits <= tsoc_pkg::BITS_24;
         half <= 1'b0;
         data_q <= 1'b0;
         en_q <= 1'b0;
         fe_q <= 1'b0;
         state <= tsoc_pkg::TSOC_IDLE;
      end
      else if (link_reset)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
         ack_tog <= 1'b0;
         fresh <= 1'b0;
         shreg <= tsoc_pkg::SHIFT_RESET;
         bit_cnt <= tsoc_pkg::CNT_RESET;
         word_bits <= tsoc_pkg::BITS_24;
         half <= 1'b0;
         data_q <= 1'b0;
         en_q <= 1'b0;
         fe_q <= 1'b0;
         state <= tsoc_pkg::TSOC_IDLE;
      end
      else
      begin
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         req_seen <= next_req_seen;
         ack_tog <= next_ack_tog;
         fresh <= next_fresh;
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         word_bits <= next_word_bits;
         half <= next_half;
         data_q <= next_data_q;
         en_q <= next_en_q;
         fe_q <= next_fe_q;
         state <= next_state;
      end
   end

   assign serial_data_out = data_q;
   assign serial_data_out_en = en_q;
   assign frame_end_flag = fe_q;
endmodule

// ===== hw/tsoc_pkg.sv
// Constants for the slave / cascade serial output port.
// Assumes a 50 MHz core clock and a host-supplied shift clock.
package tsoc_pkg;
   // Word-length field encodings
   localparam logic [1:0] WL_12 = 2'h0;
   localparam logic [1:0] WL_16 = 2'h1;
   localparam int WORD_MAX = 24;
   localparam logic [5:0] BITS_12 = 6'h0C;
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_24 = 6'h18;
   localparam logic [5:0] CNT_RESET = 6'h00;
   localparam logic [47:0] SHIFT_RESET = 48'h0;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   // Shift clock limit the host must respect
   localparam real SCLK_MAX_MHZ = 62.5;
   localparam real CORE_MHZ = 50.0;
   typedef enum logic [1:0]
   {
      TSOC_IDLE = 2'b00,
      TSOC_ARMED = 2'b01,
      TSOC_SHIFT = 2'b10
   } tsoc_state_type;
endpackage

// ===== verification/tsoc_port_assertions.sv
// Checker for the serial output port, watching tsoc_port ports only.
// Assumes the bind below places it in every tsoc_port instance.
`timescale 1ns/10ps
module tsoc_port_checker
(
   input wire logic clock,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic pair_valid,
   input wire logic frame_sync_pulse,
   input wire logic serial_data_out_en,
   input wire logic frame_end_flag,
   input wire logic channel_data_ready
);
   // ========
   // Driven bit counter on the link clock
   logic [5:0] bits;
   logic [5:0] next_bits;
   always_comb
   begin
      next_bits = serial_data_out_en ? bits + 6'h01 : 6'h00;
   end
   always_ff @(posedge shift_clock or posedge reset)
   begin
      if (reset)
         bits <= 6'h00;
      else
         bits <= next_bits;
   end
   // ========
   // Properties
   property p_rdy; @(posedge clock) disable iff (reset)
      pair_valid |=> channel_data_ready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready missing");
   property p_rdy_src; @(posedge clock) disable iff (reset)
      $rose(channel_data_ready) |-> $past(pair_valid); endproperty
   a_rdy_src: assert property (p_rdy_src) else $error("stray ready");
   property p_quiet; @(negedge shift_clock) disable iff (reset)
      !serial_data_out_en && !frame_sync_pulse |=> !serial_data_out_en;
   endproperty
   a_quiet: assert property (p_quiet) else $error("start without sync");
   property p_fe_drv; @(posedge shift_clock) disable iff (reset)
      frame_end_flag |-> serial_data_out_en; endproperty
   a_fe_drv: assert property (p_fe_drv) else $error("end while idle");
   property p_fe_once; @(posedge shift_clock) disable iff (reset)
      frame_end_flag |=> !frame_end_flag; endproperty
   a_fe_once: assert property (p_fe_once) else $error("end too long");
   property p_fe_pos; @(posedge shift_clock) disable iff (reset)
      $rose(frame_end_flag) |-> bits == 23 || bits == 31 || bits == 47;
   endproperty
   a_fe_pos: assert property (p_fe_pos) else $error("end misplaced");
   property p_len; @(posedge shift_clock) disable iff (reset)
      $fell(serial_data_out_en) |-> $past(frame_end_flag)
         && (bits == 24 || bits == 32 || bits == 48); endproperty
   a_len: assert property (p_len) else $error("slot length");
   property p_head; @(posedge shift_clock) disable iff (reset)
      $rose(serial_data_out_en) |-> serial_data_out_en [*8]; endproperty
   a_head: assert property (p_head) else $error("short slot");
endmodule
bind tsoc_port tsoc_port_checker CHK (.clock(clock), .reset(reset),
   .shift_clock(shift_clock), .pair_valid(pair_valid),
   .frame_sync_pulse(frame_sync_pulse),
   .serial_data_out_en(serial_data_out_en),
   .frame_end_flag(frame_end_flag),
   .channel_data_ready(channel_data_ready));

// ===== verification/tsoc_host_model.sv
// Host serial port model: makes shift clock and frame sync, reads frames.
// Assumes the bench calls read_frame; the clock is still between calls.
`timescale 1ns/10ps
module tsoc_host_model
(
   output logic shift_clock,
   output logic frame_sync_pulse,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en,
   input wire logic frame_end_flag
);
   logic got_d;
   logic got_en;
   logic got_fe;
   initial
   begin
      shift_clock = 1'b0;
      frame_sync_pulse = 1'b0;
   end
   // ========
   // One 160 ns period, odd offsets keep it off the core clock edges
   task automatic tick(input logic s);
      frame_sync_pulse = s;
      #43 shift_clock = 1'b1;
      // A released line is shown inverted so stray reads stand out
      #80 got_d = serial_data_out_en ? serial_data_out : !serial_data_out;
      got_en = serial_data_out_en;
      got_fe = frame_end_flag;
      shift_clock = 1'b0;
      #37;
   endtask
   task automatic read_frame(input int n, output logic [47:0] d,
      output int cnt, output int fe_at);
      d = 48'h0;
      cnt = 0;
      fe_at = 0;
      // Two idle edges release the link reset, three more let a fresh
      // pair cross into the link domain
      repeat (5) tick(1'b0);
      tick(1'b1);
      for (int k = 1; k <= 2 * n + 2; k++)
      begin
         tick(1'b0);
         if (got_en === 1'b1)
         begin
            d = {d[46:0], got_d};
            cnt++;
         end
         if (got_fe === 1'b1)
            fe_at = k;
      end
   endtask
endmodule

// ===== verification/test_tsoc_port.sv
// Self-checking bench for tsoc_port driven by the host model.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/10ps
module test_tsoc_port;
   logic clock;
   logic reset;
   logic [1:0] word_length;
   logic [23:0] i_word;
   logic [23:0] q_word;
   logic pair_valid;
   logic shift_clock;
   logic frame_sync_pulse;
   logic serial_data_out;
   logic serial_data_out_en;
   logic frame_end_flag;
   logic channel_data_ready;
   logic chain_valid;
   logic chain_data;
   logic chain_en;
   logic chain_fe;
   logic chain_ready;
   logic line_data;
   logic line_en;
   logic line_fe;
   int miscompares;
   int checked;
   tsoc_port DUT (.clock(clock), .reset(reset), .shift_clock(shift_clock),
      .word_length(word_length), .i_word(i_word), .q_word(q_word),
      .pair_valid(pair_valid), .frame_sync_pulse(frame_sync_pulse),
      .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en),
      .frame_end_flag(frame_end_flag),
      .channel_data_ready(channel_data_ready));
   // Follower port: its frame sync is the head port's frame end
   tsoc_port DUT2 (.clock(clock), .reset(reset), .shift_clock(shift_clock),
      .word_length(word_length), .i_word(q_word), .q_word(i_word),
      .pair_valid(chain_valid), .frame_sync_pulse(frame_end_flag),
      .serial_data_out(chain_data), .serial_data_out_en(chain_en),
      .frame_end_flag(chain_fe), .channel_data_ready(chain_ready));
   // Shared data line as the host sees it
   assign line_data = serial_data_out_en ? serial_data_out : chain_data;
   assign line_en = serial_data_out_en | chain_en;
   assign line_fe = frame_end_flag | chain_fe;
   tsoc_host_model HOST (.shift_clock(shift_clock),
      .frame_sync_pulse(frame_sync_pulse),
      .serial_data_out(line_data),
      .serial_data_out_en(line_en),
      .frame_end_flag(line_fe));
   // Both ports driving the shared line at once is a collision
   always @(negedge shift_clock)
   begin
      if (serial_data_out_en && chain_en)
      begin
         miscompares++;
         $display("ERROR at %0t: got %0h expected %0h", $time, 2'h3, 2'h1);
      end
   end
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ========
   // Expectations
   function automatic int width_of(input logic [1:0] wl);
      return wl == tsoc_pkg::WL_12 ? int'(tsoc_pkg::BITS_12) :
         wl == tsoc_pkg::WL_16 ? int'(tsoc_pkg::BITS_16) :
         int'(tsoc_pkg::BITS_24);
   endfunction
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ========
   // One frame; without load the sync must be ignored
   task automatic run_frame(input logic [1:0] wl, input logic [23:0] a,
      input logic [23:0] b, input logic load);
      logic [47:0] d;
      logic [47:0] e;
      int cnt;
      int fe_at;
      int n;
      n = width_of(wl);
      e = load ? ((({24'h0, a} >> (24 - n)) << n) | ({24'h0, b} >> (24 - n)))
         : 48'h0;
      if (load)
      begin
         @(posedge clock);
         word_length <= wl;
         i_word <= a;
         q_word <= b;
         pair_valid <= 1'b1;
         @(posedge clock);
         pair_valid <= 1'b0;
         #1 check(48'(channel_data_ready), 48'h1);
      end
      HOST.read_frame(n, d, cnt, fe_at);
      check(d, e);
      check(48'(cnt), load ? 48'(2 * n) : 48'h0);
      check(48'(fe_at), load ? 48'(2 * n) : 48'h0);
      check(48'(channel_data_ready), 48'h0);
   endtask
   // Head and follower each send one 12-bit pair, back to back
   task automatic run_chain(input logic [23:0] a, input logic [23:0] b);
      logic [47:0] d;
      int cnt;
      int fe_at;
      @(posedge clock);
      word_length <= tsoc_pkg::WL_12;
      i_word <= a;
      q_word <= b;
      pair_valid <= 1'b1;
      chain_valid <= 1'b1;
      @(posedge clock);
      pair_valid <= 1'b0;
      chain_valid <= 1'b0;
      HOST.read_frame(2 * int'(tsoc_pkg::BITS_12), d, cnt, fe_at);
      check(d, {a[23:12], b[23:12], b[23:12], a[23:12]});
      check(48'(cnt), 48'(4 * int'(tsoc_pkg::BITS_12)));
      check(48'(fe_at), 48'(4 * int'(tsoc_pkg::BITS_12)));
      check(48'(chain_ready), 48'h0);
   endtask
   initial
   begin
      #1000000 miscompares++;
      complete_run;
   end
   initial
   begin
      reset = 1'b1;
      pair_valid = 1'b0;
      chain_valid = 1'b0;
      word_length = 2'h0;
      i_word = 24'h0;
      q_word = 24'h0;
      miscompares = 0;
      checked = 0;
      void'($urandom(32'h7AA0B207));
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      run_frame(2'h2, 24'hFFFFFF, 24'h000000, 1'b1);
      run_frame(2'h2, 24'h0, 24'h0, 1'b0);
      for (int k = 0; k < 8; k++)
         run_frame(2'(k), 24'($urandom), 24'($urandom), 1'b1);
      run_chain(24'($urandom), 24'($urandom));
      run_chain(24'hABC123, 24'h456DEF);
      complete_run;
   end
endmodule
